/* File: design/ufc_flow_baud.sv */
// How it works
// - Second stop char with special detect in enhanced mode sets status bit 4, level-5 irq.
// - Reading additional_status clears the special-character flag.
// - Matches are accepted whatever the parity or framing status says.
// - Stop char match halts transmit after current char, sets status bits, irq.
// - Resume char match after stop re-enables transmit and clears both status bits.
// - Valid stop/resume chars are dropped, except second stop char under special detect.
// - Resume-any (enhanced mode): every received char except a stop char resumes transmit; ordinary chars are still stored.
// - Fill level sampled only while transmitter idle; flow chars inserted there.
// - Sent-stop bit clear and fill above upper level: send stop char, set bit.
// - Sent-stop bit set and fill below lower level: send resume char, clear bit.
// - Disabling transmit flow control with stop outstanding sends a resume char.
// - Auto RTS/CTS: one bit in plain mode, two separate bits in enhanced mode.
// - Auto CTS: hold off new characters while CTS is inactive high.
// - Auto RTS goes inactive at upper level, active again below lower level.
// - Auto RTS is ANDed with the software RTS bit.
// - DTR/DSR flow control works the same, enabled by additional_control bits 3:2.
// - Bit rate is clock over samples times divisor times prescaler; divisor 16 bits.
// - Prescaler divides by M plus N/8 when enabled with M nonzero, else by one.
// - Sample clock field sets 4 to 16 samples per bit.
// - After reset prescaler bypass only with clock-select pin high, and sample clock 0x00 giving 16 samples.
// - Prescaler enable resets to inverted clock-select pin; writable only in enhanced mode.
// - Prescaler register resets to 0x20, indexed control set entry 0x01.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_baud
	import ufc_pkg::*;
(
	// Clock and control
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic clock_select_pin,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Receiver side
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic rx_error,
	input wire logic [6:0] receive_fill_level,
	output logic rx_store,
	output logic [7:0] rx_store_char,
	// Transmitter side
	input wire logic tx_busy,
	input wire logic tx_char_done,
	input wire logic tx_holding_empty,
	output logic tx_allow,
	output logic tx_insert,
	output logic [7:0] tx_insert_char,
	// Modem lines
	input wire logic cts_n,
	input wire logic dsr_n,
	output logic rts_n,
	output logic dtr_n,
	// Baud generation and level-5 interrupt
	output logic sample_tick,
	output logic [4:0] samples_per_bit,
	output logic level5_irq
);
	typedef struct packed {
		logic [7:0] div_low;
		logic [7:0] div_high;
		logic [7:0] prescaler;
		logic [7:0] sample_clock;
		logic [7:0] modem_control;
		logic [7:0] enhanced;
		logic [7:0] add_control;
		logic [7:0] int_enable;
		logic [7:0] first_resume;
		logic [7:0] second_resume;
		logic [7:0] first_stop;
		logic [7:0] second_stop;
		logic [6:0] upper_trig;
		logic [6:0] lower_trig;
		logic remote_xoff;
		logic sent_xoff;
		logic special;
		logic rts_hold;
		logic dtr_hold;
		logic tx_first_set;
		logic strap_done;
		ufc_tx_state_t tx_state;
		logic [10:0] pre_acc;
		logic [15:0] div_cnt;
		logic [7:0] rdata;
		logic rx_store;
		logic [7:0] rx_store_char;
		logic tx_allow;
		logic tx_insert;
		logic [7:0] tx_insert_char;
		logic rts_n;
		logic dtr_n;
		logic tick;
		logic [4:0] spb;
		logic irq;
	} ufc_state_t;

	ufc_state_t s_q, s_d;

	function automatic logic [4:0] spb_of(input logic [SC_FIELD_W-1:0] f);
		spb_of = ({1'b0, f} < SPB_MIN) ? SPB_DEFAULT : {1'b0, f};
	endfunction : spb_of

	function automatic logic [7:0] read_mux(input ufc_state_t s, input logic [3:0] a);
		read_mux = RST_ZERO;
		case (a)
			OFS_DIV_LOW: read_mux = s.div_low;
			OFS_DIV_HIGH: read_mux = s.div_high;
			OFS_CLOCK_PRESCALER: read_mux = s.prescaler;
			OFS_SAMPLE_CLOCK: read_mux = s.sample_clock;
			OFS_MODEM_CONTROL: read_mux = s.modem_control;
			OFS_ENHANCED: read_mux = s.enhanced;
			OFS_ADD_CONTROL: read_mux = s.add_control;
			OFS_INT_ENABLE: read_mux = s.int_enable;
			OFS_INT_SOURCE: read_mux = {3'h0, s.remote_xoff, 4'h0};
			OFS_ADD_STATUS: read_mux = {3'h0, s.special, 2'h0, s.sent_xoff, s.remote_xoff};
			OFS_FIRST_RESUME: read_mux = s.first_resume;
			OFS_SECOND_RESUME: read_mux = s.second_resume;
			OFS_FIRST_STOP: read_mux = s.first_stop;
			OFS_SECOND_STOP: read_mux = s.second_stop;
			OFS_UPPER_TRIG: read_mux = {1'b0, s.upper_trig};
			OFS_LOWER_TRIG: read_mux = {1'b0, s.lower_trig};
			default: read_mux = RST_ZERO;
		endcase
	endfunction : read_mux

	logic enh, rx_mode1, rx_mode2, tx_on, m_stop1, m_stop2, m_res, is_stop, is_res;
	logic special_hit, auto_rts, auto_cts, auto_dtr, auto_dsr, tx_idle, inb_ok;
	logic [10:0] pre_step, pre_sum;
	logic pre_tick, pre_on;
	logic [15:0] divisor;

	always_comb begin
		enh = s_q.enhanced[EF_ENHANCED];
		inb_ok = enh && s_q.enhanced[EF_ENHANCED];
		// Receive mode: bit 1 selects set 1, bit 0 selects set 2
		rx_mode1 = inb_ok && s_q.enhanced[EF_RX_SET1];
		rx_mode2 = inb_ok && s_q.enhanced[EF_RX_SET2];
		tx_on = inb_ok && (s_q.enhanced[EF_TX_SET1] ^ s_q.enhanced[EF_TX_SET2]);
		// Match ignores rx_error on purpose
		m_stop1 = rx_mode1 && rx_char == s_q.first_stop;
		m_stop2 = rx_mode2 && rx_char == s_q.second_stop;
		m_res = (rx_mode1 && rx_char == s_q.first_resume) || (rx_mode2 && rx_char == s_q.second_resume);
		is_stop = rx_valid && (m_stop1 || m_stop2);
		is_res = rx_valid && m_res && !is_stop;
		special_hit = rx_valid && enh && s_q.enhanced[EF_SPECIAL] && rx_char == s_q.second_stop;
		auto_rts = enh ? s_q.enhanced[EF_AUTO_RTS] : s_q.modem_control[MC_XON_ANY];
		auto_cts = enh ? s_q.enhanced[EF_AUTO_CTS] : s_q.modem_control[MC_XON_ANY];
		auto_dtr = s_q.add_control[AC_DTR_LO];
		auto_dsr = s_q.add_control[AC_DTR_HI];
		tx_idle = !tx_busy || tx_char_done || tx_holding_empty;
		// Prescaler in eighths: M*8+N, zero M treated as bypass
		pre_on = s_q.modem_control[MC_PRESCALE] && s_q.prescaler[7:3] != 5'h0;
		pre_step = pre_on ? {3'h0, s_q.prescaler} : 11'd8;
		pre_sum = s_q.pre_acc + 11'd8;
		pre_tick = pre_sum >= pre_step;
		divisor = {s_q.div_high, s_q.div_low};
	end

	always_comb begin
		s_d = s_q;
		s_d.rx_store = 1'b0;
		s_d.tx_insert = 1'b0;
		s_d.tick = 1'b0;
		if (!s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			s_d.modem_control[MC_PRESCALE] = ~clock_select_pin;
		end
		s_d.rdata = reg_rd ? read_mux(s_q, reg_addr) : RST_ZERO;
		if (reg_rd && reg_addr == OFS_ADD_STATUS)
			s_d.special = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				OFS_DIV_LOW: s_d.div_low = reg_wdata;
				OFS_DIV_HIGH: s_d.div_high = reg_wdata;
				OFS_CLOCK_PRESCALER: s_d.prescaler = reg_wdata;
				OFS_SAMPLE_CLOCK: s_d.sample_clock = {4'h0, reg_wdata[3:0]};
				OFS_MODEM_CONTROL: begin
					s_d.modem_control[4:0] = reg_wdata[4:0];
					s_d.modem_control[MC_XON_ANY] = reg_wdata[MC_XON_ANY];
					if (enh) begin
						s_d.modem_control[7:6] = reg_wdata[7:6];
					end
				end
				OFS_ENHANCED: s_d.enhanced = reg_wdata;
				OFS_ADD_CONTROL: s_d.add_control = reg_wdata;
				OFS_INT_ENABLE: s_d.int_enable = reg_wdata;
				OFS_FIRST_RESUME: s_d.first_resume = reg_wdata;
				OFS_SECOND_RESUME: s_d.second_resume = reg_wdata;
				OFS_FIRST_STOP: s_d.first_stop = reg_wdata;
				OFS_SECOND_STOP: s_d.second_stop = reg_wdata;
				OFS_UPPER_TRIG: s_d.upper_trig = reg_wdata[6:0];
				OFS_LOWER_TRIG: s_d.lower_trig = reg_wdata[6:0];
				default: ;
			endcase
		end
		// Set after clear, so a hit in the read cycle survives
		if (special_hit)
			s_d.special = 1'b1;
		if (is_stop)
			s_d.remote_xoff = 1'b1;
		else if (s_q.remote_xoff && (is_res || (rx_valid && enh && s_q.modem_control[MC_XON_ANY])))
			s_d.remote_xoff = 1'b0;
		// Flow characters are swallowed unless special detect keeps them
		s_d.rx_store_char = rx_char;
		s_d.rx_store = rx_valid && !((is_stop || is_res) && !(m_stop2 && s_q.enhanced[EF_SPECIAL]));
		// Out-of-band hysteresis
		if (receive_fill_level >= s_q.upper_trig)
			s_d.rts_hold = 1'b1;
		else if (receive_fill_level < s_q.lower_trig)
			s_d.rts_hold = 1'b0;
		s_d.dtr_hold = s_d.rts_hold;
		s_d.rts_n = !(s_q.modem_control[MC_RTS] && !(auto_rts && s_q.rts_hold));
		s_d.dtr_n = !(s_q.modem_control[MC_DTR] && !(auto_dtr && s_q.dtr_hold));
		// Transmit gating and flow-char insertion
		// Remember the set in use so a forced resume matches the stop sent
		if (tx_on)
			s_d.tx_first_set = s_q.enhanced[EF_TX_SET1];
		case (s_q.tx_state)
			UFC_TX_IDLE: begin
				if (tx_idle) begin
					if (tx_on && !s_q.sent_xoff && receive_fill_level > s_q.upper_trig) begin
						s_d.tx_insert = 1'b1;
						s_d.tx_insert_char = s_q.enhanced[EF_TX_SET1] ? s_q.first_stop : s_q.second_stop;
						s_d.sent_xoff = 1'b1;
					end else if (s_q.sent_xoff && ((tx_on && receive_fill_level < s_q.lower_trig) || !tx_on)) begin
						s_d.tx_insert = 1'b1;
						if (tx_on)
							s_d.tx_insert_char = s_q.enhanced[EF_TX_SET1] ? s_q.first_resume : s_q.second_resume;
						else
							s_d.tx_insert_char = s_q.tx_first_set ? s_q.first_resume : s_q.second_resume;
						s_d.sent_xoff = 1'b0;
					end
				end
				if (tx_busy)
					s_d.tx_state = UFC_TX_BUSY;
			end
			UFC_TX_BUSY: begin
				if (tx_char_done || !tx_busy)
					s_d.tx_state = UFC_TX_IDLE;
			end
			default: s_d.tx_state = UFC_TX_IDLE;
		endcase
		// Hold-off only takes effect between characters
		if (s_q.tx_state == UFC_TX_IDLE || tx_char_done)
			s_d.tx_allow = !s_d.remote_xoff && !(auto_cts && cts_n) && !(auto_dsr && dsr_n);
		s_d.irq = s_q.int_enable[IE_LEVEL5] && enh && (s_d.remote_xoff || s_d.special);
		// Baud chain: fractional prescaler then divisor
		s_d.spb = spb_of(s_q.sample_clock[SC_FIELD_W-1:0]);
		if (pre_tick) begin
			s_d.pre_acc = pre_sum - pre_step;
			if (s_q.div_cnt + 16'd1 >= divisor) begin
				s_d.div_cnt = 16'h0;
				s_d.tick = 1'b1;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 16'd1;
			end
		end else begin
			s_d.pre_acc = pre_sum;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.div_low <= RST_DIV_LOW;
			s_q.div_high <= RST_DIV_HIGH;
			s_q.prescaler <= RST_CLOCK_PRESCALER;
			s_q.sample_clock <= RST_SAMPLE_CLOCK;
			s_q.upper_trig <= RST_UPPER_TRIG;
			s_q.lower_trig <= RST_LOWER_TRIG;
			s_q.tx_state <= UFC_TX_IDLE;
			s_q.tx_allow <= 1'b1;
			s_q.rts_n <= 1'b1;
			s_q.dtr_n <= 1'b1;
			s_q.spb <= SPB_DEFAULT;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign rx_store = s_q.rx_store;
	assign rx_store_char = s_q.rx_store_char;
	assign tx_allow = s_q.tx_allow;
	assign tx_insert = s_q.tx_insert;
	assign tx_insert_char = s_q.tx_insert_char;
	assign rts_n = s_q.rts_n;
	assign dtr_n = s_q.dtr_n;
	assign sample_tick = s_q.tick;
	assign samples_per_bit = s_q.spb;
	assign level5_irq = s_q.irq;

	special_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && special_hit |=> s_q.special)
		else $error("special flag not set");
	status_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == OFS_ADD_STATUS && !special_hit |=> !s_q.special)
		else $error("special flag not cleared by read");
	stop_halts_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && is_stop |=> s_q.remote_xoff)
		else $error("stop char did not set xoff");
	resume_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && s_q.remote_xoff && is_res |=> !s_q.remote_xoff)
		else $error("resume char did not clear xoff");
	drop_flow_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && is_res && !s_q.modem_control[MC_XON_ANY] |=> !rx_store)
		else $error("resume char stored");
	store_any_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rx_valid && !is_stop && !is_res |=> rx_store && rx_store_char == $past(rx_char))
		else $error("ordinary char not stored");
	rts_and_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !s_q.modem_control[MC_RTS] |=> rts_n)
		else $error("rts active with software bit clear");
	send_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && tx_insert && s_q.sent_xoff && !$past(s_q.sent_xoff) |-> tx_insert_char == $past(s_q.first_stop)
		|| tx_insert_char == $past(s_q.second_stop))
		else $error("wrong stop char sent");
	spb_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		samples_per_bit >= SPB_MIN && samples_per_bit <= SPB_DEFAULT)
		else $error("samples per bit out of range");
	irq_on_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && is_stop && s_q.int_enable[IE_LEVEL5] |=> level5_irq)
		else $error("no level 5 irq on stop char");
	irq_on_special_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && special_hit && s_q.int_enable[IE_LEVEL5] |=> level5_irq)
		else $error("no level 5 irq on special char");
	resume_any_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rx_valid && enh && s_q.modem_control[MC_XON_ANY] && !is_stop |=> !s_q.remote_xoff)
		else $error("resume-any did not clear xoff");
	keep_second_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && is_stop && m_stop2 && s_q.enhanced[EF_SPECIAL] |=> rx_store)
		else $error("second stop char not stored");
	drop_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && is_stop && !(m_stop2 && s_q.enhanced[EF_SPECIAL]) |=> !rx_store)
		else $error("stop char stored");
	rts_hold_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && receive_fill_level >= s_q.upper_trig |=> s_q.rts_hold)
		else $error("rts hold not set at upper level");
	rts_release_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && receive_fill_level < s_q.lower_trig && receive_fill_level < s_q.upper_trig |=> !s_q.rts_hold)
		else $error("rts hold not released below lower level");
	rts_forced_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && auto_rts && s_q.rts_hold |=> rts_n)
		else $error("rts active while held off");
	dtr_and_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !s_q.modem_control[MC_DTR] |=> dtr_n)
		else $error("dtr active with software bit clear");
	cts_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && s_q.tx_state == UFC_TX_IDLE && auto_cts && cts_n |=> !tx_allow)
		else $error("transmit allowed with cts inactive");
	dsr_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && s_q.tx_state == UFC_TX_IDLE && auto_dsr && dsr_n |=> !tx_allow)
		else $error("transmit allowed with dsr inactive");
	xoff_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && s_q.tx_state == UFC_TX_IDLE && is_stop |=> !tx_allow)
		else $error("transmit allowed after stop char");
	idle_insert_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !tx_idle |=> !tx_insert)
		else $error("flow char inserted while transmitter busy");
	stop_insert_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && tx_on && tx_idle && s_q.tx_state == UFC_TX_IDLE && !s_q.sent_xoff
		&& receive_fill_level > s_q.upper_trig |=> tx_insert && s_q.sent_xoff)
		else $error("stop char not sent above upper level");
	send_resume_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && tx_on && tx_idle && s_q.tx_state == UFC_TX_IDLE && s_q.sent_xoff
		&& receive_fill_level < s_q.lower_trig |=> tx_insert && !s_q.sent_xoff)
		else $error("resume char not sent below lower level");
	auto_resume_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !tx_on && tx_idle && s_q.tx_state == UFC_TX_IDLE && s_q.sent_xoff |=> tx_insert && !s_q.sent_xoff)
		else $error("resume char not sent after flow control off");
	prescale_bypass_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !s_q.modem_control[MC_PRESCALE] |-> pre_tick)
		else $error("prescaler not bypassed");
	strap_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !s_q.strap_done |=> s_q.modem_control[MC_PRESCALE] == ~$past(clock_select_pin))
		else $error("prescaler enable not loaded from strap");
	mcr_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == OFS_MODEM_CONTROL && !enh && s_q.strap_done
		|=> s_q.modem_control[MC_PRESCALE] == $past(s_q.modem_control[MC_PRESCALE]))
		else $error("prescaler enable written outside enhanced mode");
endmodule : ufc_flow_baud
`default_nettype wire

/* File: design/ufc_pkg.sv */
package ufc_pkg;
	// Register offsets on the plain port (byte index into the channel's space)
	localparam logic [3:0] OFS_DIV_LOW = 4'h0;
	localparam logic [3:0] OFS_DIV_HIGH = 4'h1;
	localparam logic [3:0] OFS_CLOCK_PRESCALER = 4'h2;
	localparam logic [3:0] OFS_SAMPLE_CLOCK = 4'h3;
	localparam logic [3:0] OFS_MODEM_CONTROL = 4'h4;
	localparam logic [3:0] OFS_ENHANCED = 4'h5;
	localparam logic [3:0] OFS_ADD_CONTROL = 4'h6;
	localparam logic [3:0] OFS_INT_ENABLE = 4'h7;
	localparam logic [3:0] OFS_INT_SOURCE = 4'h8;
	localparam logic [3:0] OFS_ADD_STATUS = 4'h9;
	localparam logic [3:0] OFS_FIRST_RESUME = 4'hA;
	localparam logic [3:0] OFS_SECOND_RESUME = 4'hB;
	localparam logic [3:0] OFS_FIRST_STOP = 4'hC;
	localparam logic [3:0] OFS_SECOND_STOP = 4'hD;
	localparam logic [3:0] OFS_UPPER_TRIG = 4'hE;
	localparam logic [3:0] OFS_LOWER_TRIG = 4'hF;
	// Index of the prescaler inside the indexed control set
	localparam logic [7:0] ICS_CLOCK_PRESCALER = 8'h01;
	// Reset values
	localparam logic [7:0] RST_CLOCK_PRESCALER = 8'h20;
	localparam logic [7:0] RST_SAMPLE_CLOCK = 8'h00;
	localparam logic [7:0] RST_DIV_LOW = 8'h01;
	localparam logic [7:0] RST_DIV_HIGH = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [6:0] RST_UPPER_TRIG = 7'h60;
	localparam logic [6:0] RST_LOWER_TRIG = 7'h20;
	// Field positions
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_XON_ANY = 5;
	localparam int MC_PRESCALE = 7;
	localparam int EF_RX_SET2 = 0;
	localparam int EF_RX_SET1 = 1;
	localparam int EF_TX_SET2 = 2;
	localparam int EF_TX_SET1 = 3;
	localparam int EF_ENHANCED = 4;
	localparam int EF_SPECIAL = 5;
	localparam int EF_AUTO_RTS = 6;
	localparam int EF_AUTO_CTS = 7;
	localparam int IE_LEVEL5 = 5;
	localparam int IS_XOFF = 4;
	localparam int AS_REMOTE_XOFF = 0;
	localparam int AS_SENT_XOFF = 1;
	localparam int AS_SPECIAL = 4;
	localparam int AC_DTR_LO = 2;
	localparam int AC_DTR_HI = 3;
	localparam int SC_FIELD_W = 4;
	localparam logic [4:0] SPB_DEFAULT = 5'd16;
	localparam logic [4:0] SPB_MIN = 5'd4;
	typedef enum logic [1:0] {UFC_TX_IDLE, UFC_TX_BUSY} ufc_tx_state_t;
endpackage : ufc_pkg

/* File: verif/ufc_flow_baud_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_baud_tb_top;
	import ufc_pkg::*;
	logic ref_clk, rst, reg_wr, reg_rd, tx_busy, tx_holding_empty, send, send_err, pause, clk_sel;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, send_char, ins_c, st_c, reg_rdata, rx_char, tx_insert_char, rx_store_char;
	logic [6:0] receive_fill_level;
	logic rx_valid, rx_error, rx_store, tx_allow, tx_insert, cts_n, dsr_n, rts_n, dtr_n, sample_tick, level5_irq;
	logic [4:0] samples_per_bit;
	int n_mismatch, total_checks, cyc, n_ins, n_st;
	ufc_flow_baud dut (.ref_clk, .rst, .clk_en(1'b1), .clock_select_pin(clk_sel), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rx_valid, .rx_char, .rx_error, .receive_fill_level, .rx_store, .rx_store_char,
		.tx_busy, .tx_char_done(1'b0), .tx_holding_empty, .tx_allow, .tx_insert, .tx_insert_char, .cts_n,
		.dsr_n, .rts_n, .dtr_n, .sample_tick, .samples_per_bit, .level5_irq);
	ufc_remote_port remote (.ref_clk, .send, .send_char, .send_err, .pause, .rx_valid, .rx_char, .rx_error,
		.cts_n, .dsr_n);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task give_verdict;
		if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task w(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : w
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata & m}, {8'h00, e});
	endtask : rd
	task rx(input logic [7:0] c, input logic e);
		@(posedge ref_clk);
		send <= 1'b1;
		send_char <= c;
		send_err <= e;
		@(posedge ref_clk);
		send <= 1'b0;
		w(4);
	endtask : rx
	task fl(input logic [6:0] f);
		@(posedge ref_clk);
		receive_fill_level <= f;
		w(5);
	endtask : fl
	task pz(input logic v);
		@(posedge ref_clk);
		pause <= v;
		w(4);
	endtask : pz
	// Clocks from one sample tick to the next, after the new setting settles
	task gap(input logic [15:0] e);
		int n;
		w(1);
		for (n = 0; n < 2000 && sample_tick !== 1'b1; n++) w(1);
		w(1);
		for (n = 0; n < 2000 && sample_tick !== 1'b1; n++) w(1);
		for (n = 1; n < 2000; n++) begin
			w(1);
			if (sample_tick === 1'b1) break;
		end
		chk(16'(n), e);
	endtask : gap
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (tx_insert === 1'b1) begin
			n_ins <= n_ins + 1;
			ins_c <= tx_insert_char;
		end
		if (rx_store === 1'b1) begin
			n_st <= n_st + 1;
			st_c <= rx_store_char;
		end
		if (cyc == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		{reg_wr, reg_rd, tx_busy, send, send_err, pause, cyc, n_ins, n_st, n_mismatch, total_checks} = '0;
		{reg_addr, reg_wdata, send_char, receive_fill_level} = '0;
		tx_holding_empty = 1'b1;
		rst = 1'b1;
		clk_sel = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		w(2);
		rd(OFS_MODEM_CONTROL, 8'h80, 8'h80);
		// Second reset with the strap high
		@(posedge ref_clk);
		rst <= 1'b1;
		clk_sel <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		w(2);
		rd(OFS_CLOCK_PRESCALER, 8'hFF, 8'h20);
		rd(OFS_SAMPLE_CLOCK, 8'hFF, 8'h00);
		chk(16'(samples_per_bit), 16'h0010);
		rd(OFS_MODEM_CONTROL, 8'h80, 8'h00);
		wr(OFS_MODEM_CONTROL, 8'h80);
		rd(OFS_MODEM_CONTROL, 8'h80, 8'h00);
		wr(OFS_DIV_LOW, 8'h03);
		gap(16'h0003);
		wr(OFS_ENHANCED, 8'h10);
		wr(OFS_MODEM_CONTROL, 8'h80);
		rd(OFS_MODEM_CONTROL, 8'h80, 8'h80);
		wr(OFS_CLOCK_PRESCALER, 8'h10);
		gap(16'h0006);
		wr(OFS_MODEM_CONTROL, 8'h00);
		wr(OFS_DIV_HIGH, 8'h01);
		wr(OFS_DIV_LOW, 8'h00);
		gap(16'h0100);
		wr(OFS_SAMPLE_CLOCK, 8'h03);
		w(3);
		chk(16'(samples_per_bit), 16'h0010);
		wr(OFS_SAMPLE_CLOCK, 8'h04);
		w(3);
		chk(16'(samples_per_bit), 16'h0004);
		wr(OFS_SAMPLE_CLOCK, 8'h0F);
		w(3);
		chk(16'(samples_per_bit), 16'h000F);
		wr(OFS_FIRST_STOP, 8'h13);
		wr(OFS_FIRST_RESUME, 8'h11);
		wr(OFS_SECOND_STOP, 8'h93);
		wr(OFS_INT_ENABLE, 8'h20);
		wr(OFS_ENHANCED, 8'h12);
		rx(8'h13, 1'b1);
		chk({15'h0, tx_allow}, 16'h0000);
		chk({15'h0, level5_irq}, 16'h0001);
		rd(OFS_INT_SOURCE, 8'h10, 8'h10);
		rd(OFS_ADD_STATUS, 8'h01, 8'h01);
		rx(8'h11, 1'b0);
		chk({15'h0, tx_allow}, 16'h0001);
		rd(OFS_INT_SOURCE, 8'h10, 8'h00);
		rd(OFS_ADD_STATUS, 8'h01, 8'h00);
		rx(8'h41, 1'b0);
		chk(16'(n_st), 16'h0001);
		wr(OFS_ENHANCED, 8'h31);
		rx(8'h93, 1'b1);
		chk({8'h00, st_c}, 16'h0093);
		chk({15'h0, tx_allow}, 16'h0000);
		rd(OFS_ADD_STATUS, 8'h10, 8'h10);
		rd(OFS_ADD_STATUS, 8'h10, 8'h00);
		wr(OFS_MODEM_CONTROL, 8'h20);
		rx(8'h55, 1'b0);
		chk({15'h0, tx_allow}, 16'h0001);
		chk({8'h00, st_c}, 16'h0055);
		chk(16'(n_st), 16'h0003);
		wr(OFS_MODEM_CONTROL, 8'h00);
		wr(OFS_ENHANCED, 8'h18);
		@(posedge ref_clk);
		tx_busy <= 1'b1;
		tx_holding_empty <= 1'b0;
		fl(7'h60);
		fl(7'h61);
		chk(16'(n_ins), 16'h0000);
		@(posedge ref_clk);
		tx_busy <= 1'b0;
		w(5);
		chk({8'h00, ins_c}, 16'h0013);
		rd(OFS_ADD_STATUS, 8'h02, 8'h02);
		fl(7'h20);
		chk(16'(n_ins), 16'h0001);
		fl(7'h1F);
		chk({8'h00, ins_c}, 16'h0011);
		rd(OFS_ADD_STATUS, 8'h02, 8'h00);
		fl(7'h61);
		wr(OFS_ENHANCED, 8'h10);
		w(5);
		chk({8'h00, ins_c}, 16'h0011);
		chk(16'(n_ins), 16'h0004);
		fl(7'h00);
		wr(OFS_ENHANCED, 8'h50);
		wr(OFS_MODEM_CONTROL, 8'h02);
		fl(7'h5F);
		chk({15'h0, rts_n}, 16'h0000);
		fl(7'h60);
		chk({15'h0, rts_n}, 16'h0001);
		fl(7'h20);
		chk({15'h0, rts_n}, 16'h0001);
		fl(7'h1F);
		chk({15'h0, rts_n}, 16'h0000);
		wr(OFS_MODEM_CONTROL, 8'h00);
		w(4);
		chk({15'h0, rts_n}, 16'h0001);
		wr(OFS_ENHANCED, 8'h00);
		wr(OFS_MODEM_CONTROL, 8'h22);
		fl(7'h60);
		chk({15'h0, rts_n}, 16'h0001);
		pz(1'b1);
		chk({15'h0, tx_allow}, 16'h0000);
		pz(1'b0);
		chk({15'h0, tx_allow}, 16'h0001);
		wr(OFS_MODEM_CONTROL, 8'h02);
		wr(OFS_ENHANCED, 8'h90);
		fl(7'h00);
		fl(7'h60);
		chk({15'h0, rts_n}, 16'h0000);
		pz(1'b1);
		chk({15'h0, tx_allow}, 16'h0000);
		pz(1'b0);
		wr(OFS_ENHANCED, 8'h00);
		wr(OFS_ADD_CONTROL, 8'h0C);
		wr(OFS_MODEM_CONTROL, 8'h03);
		fl(7'h00);
		chk({15'h0, dtr_n}, 16'h0000);
		fl(7'h60);
		chk({15'h0, dtr_n}, 16'h0001);
		pz(1'b1);
		chk({15'h0, tx_allow}, 16'h0000);
		give_verdict();
	end
endmodule : ufc_flow_baud_tb_top
`default_nettype wire

/* File: verif/ufc_remote_port.sv */
`timescale 1ns/1ps
`default_nettype none
module ufc_remote_port (
	// Clock
	input wire logic ref_clk,
	// Commands from the bench
	input wire logic send,
	input wire logic [7:0] send_char,
	input wire logic send_err,
	input wire logic pause,
	// Lines towards the channel
	output logic rx_valid,
	output logic [7:0] rx_char,
	output logic rx_error,
	output logic cts_n,
	output logic dsr_n
);
	initial begin
		rx_valid = 1'b0;
		rx_char = 8'h00;
		rx_error = 1'b0;
		cts_n = 1'b0;
		dsr_n = 1'b0;
	end
	always @(posedge ref_clk) begin
		rx_valid <= send;
		// Idle data shows the inverse of the last value
		rx_char <= send ? send_char : ~rx_char;
		rx_error <= send & send_err;
		// Inactive high to pause the channel
		cts_n <= pause;
		dsr_n <= pause;
	end
endmodule : ufc_remote_port
`default_nettype wire
